//--- rtl/lsir_pkg.sv
package lsir_pkg;
  // Register addresses (direct SA3..SA0, bank in upper bits)
  localparam logic [3:0] TX_STATUS_ADDR = 4'h0;
  localparam logic [3:0] RX_STATUS_ADDR = 4'h1;
  localparam logic [3:0] TX_IRQ_ENABLE_ADDR = 4'h2;
  localparam logic [3:0] RX_IRQ_ENABLE_ADDR = 4'h3;
  localparam logic [3:0] TX_MODE_ADDR = 4'h4;
  localparam logic [3:0] RX_MODE_ADDR = 4'h5;
  localparam logic [1:0] BANK_STATION = 2'h0;
  localparam logic [1:0] BANK_HASH = 2'h1;
  localparam logic [1:0] BANK_BUFFER = 2'h2;
  localparam logic [3:0] EXCESS_RETRY_ADDR = 4'hb;
  localparam logic [3:0] DMA_ENABLE_ADDR = 4'hc;
  localparam logic [3:0] DMA_BURST_ADDR = 4'hd;
  localparam logic [3:0] SKIP_FRAME_ADDR = 4'he;
  localparam logic [3:0] RESERVED_SLOT_ADDR = 4'hf;
  localparam logic [3:0] STATION_ADDR_BYTE0_ADDR = 4'h8;
  localparam logic [3:0] STATION_ADDR_BYTE5_ADDR = 4'hd;
  localparam logic [3:0] CABLE_TEST_LOW_ADDR = 4'he;
  localparam logic [3:0] CABLE_TEST_HIGH_ADDR = 4'hf;
  localparam logic [3:0] HASH_BYTE0_ADDR = 4'h8;
  // Bit positions
  localparam int TX_DONE_BIT = 7;
  localparam int CARRIER_BIT = 6;
  localparam int SELF_RX_BIT = 5;
  localparam int CARRIER_DROP_BIT = 4;
  localparam int RETRY_BIT = 2;
  localparam int RETRY_LIMIT_BIT = 1;
  localparam int FRAME_OK_BIT = 5;
  localparam logic [7:0] TX_W1C_MASK = 8'h86;
  localparam logic [7:0] TX_IRQ_MASK = 8'h86;
  localparam logic [7:0] RX_W1C_MASK = 8'hff;
  localparam logic [7:0] RX_DMA_END_MASK = 8'h20;
  localparam logic [7:0] DMA_ENABLE_MASK = 8'h03;
  localparam logic [7:0] DMA_BURST_MASK = 8'h03;
  localparam logic [7:0] EXCESS_RETRY_MASK = 8'h07;
  localparam logic [7:0] SKIP_MASK = 8'h04;
  localparam logic [7:0] RX_MODE_MASK = 8'hbf;
  localparam logic [7:0] RX_MODE_RESET = 8'h05;
  localparam logic [7:0] RX_MODE_FORCE1 = 8'h04;
  localparam logic [7:0] TX_MODE_RESET = 8'h06;
  localparam logic [7:0] TX_MODE_MASK = 8'h07;
  localparam logic [7:0] ZERO8 = 8'h00;
  localparam int KEEP_ERR_BIT = 5;
  localparam int KEEP_RUNT_BIT = 3;
  localparam int LOOPBACK_N_BIT = 1;
  // Frame checks
  localparam logic [15:0] REMOTE_TYPE = 16'h0900;
  localparam logic [10:0] MIN_FRAME_LEN = 11'd60;
  localparam logic [3:0] RETRY_MAX = 4'hf;
  // Read-ready timeout: 2.4 us at 50 MHz, rounded down
  localparam int READ_TIMEOUT_NS = 2400;
  localparam int CLK_PERIOD_NS = 20;
  localparam int READ_TIMEOUT_CYC = READ_TIMEOUT_NS / CLK_PERIOD_NS;

  typedef struct packed {
    logic tx_start;
    logic tx_all_done;
    logic collision;
    logic tx_success;
    logic tx_active;
    logic self_rx_good;
  } lsir_tx_ev_t;

  typedef struct packed {
    logic frame_end;
    logic frame_stored;
    logic [2:0] dribble_bits;
    logic crc_bad;
    logic [10:0] frame_len;
    logic [15:0] type_field;
    logic buffer_full;
  } lsir_rx_ev_t;

  typedef struct packed {
    logic [7:0] status;
    logic [7:0] reserved;
    logic [7:0] len_low;
    logic [7:0] len_high;
  } lsir_rx_hdr_t;
endpackage

//--- rtl/lsir_regs.sv
`timescale 1ns/1ps
// Summary of operation
// - Tx done, collision, retry limit: write-one clear
// - Rx status bits hardware set, write-one clear
// - Clearing status also removes its interrupt
// - Tx done sets after whole buffer finished
// - Carrier image follows carrier sense live
// - Self receive flag, cleared at transmit start
// - Carrier drop flag, cleared at transmit start
// - Collision flag, retry up to fifteen, count readable
// - Retry limit flag after sixteenth failure
// - Packet stored flag on each stored frame
// - Read timeout flag after 2.4 us
// - Dma end flag blocks requests, cleared via enable
// - Remote frame flag on type 0900h
// - Runt flag below sixty bytes
// - Alignment flag on one to seven extra bits
// - Crc error flag on failed check
// - Overflow flag on rejected frame, not loopback
// - Error bits into header, else discard
// - Only tx bits 7, 2, 1 interrupt
// - Four byte receive header layout
// - Interrupt when set bit enabled
module lsir_regs (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic [1:0] bank_sel,
  input wire logic [3:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire logic carrier_sense,
  input wire logic dma_end_flag_n,
  input wire logic buf_rd_strobe,
  input wire logic buf_rd_ready,
  input wire lsir_pkg::lsir_tx_ev_t tx_ev,
  input wire lsir_pkg::lsir_rx_ev_t rx_ev,
  output logic irq,
  output logic dma_req_allow,
  output logic retransmit,
  output logic frame_keep,
  output logic frame_discard,
  output lsir_pkg::lsir_rx_hdr_t rx_hdr,
  output logic [1:0] dma_enable,
  output logic [1:0] dma_burst,
  output logic [2:0] excess_retry_mode,
  output logic drop_frame_cmd,
  output logic loopback_n
);
  logic [2:0] cs_sync_q;
  logic [2:0] eop_sync_q;
  logic carrier_image;
  logic eop_seen;
  logic [7:0] tx_stat_q;
  logic [7:0] rx_stat_q;
  logic [7:0] tx_ien_q;
  logic [7:0] rx_ien_q;
  logic [7:0] tx_mode_q;
  logic [7:0] rx_mode_q;
  logic [7:0] dma_en_q;
  logic [7:0] burst_q;
  logic [7:0] retry_ctl_q;
  logic [3:0] col_cnt_q;
  logic [7:0] to_cnt_q;
  logic to_fire;
  logic [7:0] station_q [0:5];
  logic [7:0] hash_q [0:7];
  logic [7:0] rx_err;
  logic runt;
  logic err_any;
  logic stat_wr_tx;
  logic stat_wr_rx;
  logic dma_wr;
  logic [7:0] rx_set;
  logic [7:0] rx_clr;

  function automatic logic hit(input logic [1:0] bank, input logic [3:0] a,
                               input logic [1:0] wb, input logic [3:0] wa);
    hit = (a[3] == 1'b0) ? (a == wa) : ((bank == wb) && (a == wa));
  endfunction

  assign stat_wr_tx = reg_wr && hit(bank_sel, reg_addr, 2'h0,
                                    lsir_pkg::TX_STATUS_ADDR);
  assign stat_wr_rx = reg_wr && hit(bank_sel, reg_addr, 2'h0,
                                    lsir_pkg::RX_STATUS_ADDR);
  assign dma_wr = reg_wr && hit(bank_sel, reg_addr, lsir_pkg::BANK_BUFFER,
                                lsir_pkg::DMA_ENABLE_ADDR);

  // Pin synchronisers, change taken when stages 2 and 3 agree
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cs_sync_q <= 3'h0;
      eop_sync_q <= 3'h7;
    end else if (clk_en) begin
      cs_sync_q <= {cs_sync_q[1:0], carrier_sense};
      eop_sync_q <= {eop_sync_q[1:0], dma_end_flag_n};
    end
  end

  logic carrier_q;
  logic eop_n_q;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      carrier_q <= 1'b0;
      eop_n_q <= 1'b1;
    end else if (clk_en) begin
      if (cs_sync_q[1] == cs_sync_q[2])
        carrier_q <= cs_sync_q[2];
      if (eop_sync_q[1] == eop_sync_q[2])
        eop_n_q <= eop_sync_q[2];
    end
  end
  assign carrier_image = carrier_q;
  assign eop_seen = !eop_n_q;

  // Receive frame checks
  assign runt = rx_ev.frame_len < lsir_pkg::MIN_FRAME_LEN;
  always_comb begin
    rx_err = lsir_pkg::ZERO8;
    rx_err[4] = rx_ev.type_field == lsir_pkg::REMOTE_TYPE;
    rx_err[3] = runt;
    rx_err[2] = rx_ev.dribble_bits != 3'h0;
    rx_err[1] = rx_ev.crc_bad;
  end
  assign err_any = |rx_err[3:1];

  // Keep or discard the frame by error filter mode
  always_comb begin
    frame_keep = !err_any;
    if (rx_mode_q[lsir_pkg::KEEP_ERR_BIT])
      frame_keep = 1'b1;
    else if (rx_mode_q[lsir_pkg::KEEP_RUNT_BIT] && !rx_err[2] && !rx_err[1])
      frame_keep = 1'b1;
  end
  assign frame_discard = rx_ev.frame_end && !frame_keep;

  // Header status, reserved and length bytes
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_hdr <= '0;
    end else if (clk_en && rx_ev.frame_end && frame_keep) begin
      rx_hdr.status <= {2'b00, !err_any, rx_err[4:1], rx_ev.buffer_full};
      rx_hdr.reserved <= lsir_pkg::ZERO8;
      rx_hdr.len_low <= rx_ev.frame_len[7:0];
      rx_hdr.len_high <= {5'b00000, rx_ev.frame_len[10:8]};
    end
  end

  // Read-ready timeout counter
  assign to_fire = to_cnt_q == 8'(lsir_pkg::READ_TIMEOUT_CYC);
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      to_cnt_q <= 8'h00;
    end else if (clk_en) begin
      if (!buf_rd_strobe || buf_rd_ready)
        to_cnt_q <= 8'h00;
      else if (!to_fire)
        to_cnt_q <= to_cnt_q + 8'h01;
    end
  end

  // Collision counter and retransmit request
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      col_cnt_q <= 4'h0;
    end else if (clk_en) begin
      if (tx_ev.tx_success || tx_ev.tx_start)
        col_cnt_q <= 4'h0;
      else if (tx_ev.collision)
        col_cnt_q <= col_cnt_q + 4'h1;
    end
  end
  assign retransmit = tx_ev.collision && (col_cnt_q != lsir_pkg::RETRY_MAX);

  // Transmit status, set beats clear
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_stat_q <= lsir_pkg::ZERO8;
    end else if (clk_en) begin
      if (stat_wr_tx)
        tx_stat_q <= tx_stat_q & ~(reg_wdata & lsir_pkg::TX_W1C_MASK);
      if (tx_ev.tx_start) begin
        tx_stat_q[lsir_pkg::SELF_RX_BIT] <= 1'b0;
        tx_stat_q[lsir_pkg::CARRIER_DROP_BIT] <= 1'b0;
      end
      if (tx_ev.self_rx_good)
        tx_stat_q[lsir_pkg::SELF_RX_BIT] <= 1'b1;
      if (tx_ev.tx_active && !carrier_image)
        tx_stat_q[lsir_pkg::CARRIER_DROP_BIT] <= 1'b1;
      if (tx_ev.tx_all_done)
        tx_stat_q[lsir_pkg::TX_DONE_BIT] <= 1'b1;
      if (tx_ev.collision)
        tx_stat_q[lsir_pkg::RETRY_BIT] <= 1'b1;
      if (tx_ev.collision && col_cnt_q == lsir_pkg::RETRY_MAX)
        tx_stat_q[lsir_pkg::RETRY_LIMIT_BIT] <= 1'b1;
    end
  end

  // Receive status set and clear terms
  always_comb begin
    rx_set = lsir_pkg::ZERO8;
    rx_clr = lsir_pkg::ZERO8;
    if (stat_wr_rx)
      rx_clr = reg_wdata & lsir_pkg::RX_W1C_MASK;
    if (dma_wr && reg_wdata == lsir_pkg::ZERO8)
      rx_clr = rx_clr | lsir_pkg::RX_DMA_END_MASK;
    rx_set[7] = rx_ev.frame_stored;
    rx_set[6] = to_fire && buf_rd_strobe && !buf_rd_ready;
    rx_set[5] = eop_seen;
    if (rx_ev.frame_end && (frame_keep || err_any))
      rx_set[4:1] = rx_err[4:1];
    rx_set[0] = rx_ev.buffer_full && loopback_n;
  end

  // Receive status, set beats clear
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_stat_q <= lsir_pkg::ZERO8;
    end else if (clk_en) begin
      rx_stat_q <= (rx_stat_q & ~rx_clr) | rx_set;
    end
  end

  // Control registers
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_ien_q <= lsir_pkg::ZERO8;
      rx_ien_q <= lsir_pkg::ZERO8;
      tx_mode_q <= lsir_pkg::TX_MODE_RESET;
      rx_mode_q <= lsir_pkg::RX_MODE_RESET;
      dma_en_q <= lsir_pkg::ZERO8;
      burst_q <= lsir_pkg::ZERO8;
      retry_ctl_q <= lsir_pkg::ZERO8;
    end else if (clk_en && reg_wr) begin
      if (hit(bank_sel, reg_addr, 2'h0, lsir_pkg::TX_IRQ_ENABLE_ADDR))
        tx_ien_q <= reg_wdata & lsir_pkg::TX_IRQ_MASK;
      if (hit(bank_sel, reg_addr, 2'h0, lsir_pkg::RX_IRQ_ENABLE_ADDR))
        rx_ien_q <= reg_wdata;
      if (hit(bank_sel, reg_addr, 2'h0, lsir_pkg::TX_MODE_ADDR))
        tx_mode_q <= reg_wdata & lsir_pkg::TX_MODE_MASK;
      if (hit(bank_sel, reg_addr, 2'h0, lsir_pkg::RX_MODE_ADDR))
        rx_mode_q <= (reg_wdata & lsir_pkg::RX_MODE_MASK)
                     | lsir_pkg::RX_MODE_FORCE1;
      if (dma_wr)
        dma_en_q <= reg_wdata & lsir_pkg::DMA_ENABLE_MASK;
      if (hit(bank_sel, reg_addr, lsir_pkg::BANK_BUFFER,
              lsir_pkg::DMA_BURST_ADDR))
        burst_q <= reg_wdata & lsir_pkg::DMA_BURST_MASK;
      if (hit(bank_sel, reg_addr, lsir_pkg::BANK_BUFFER,
              lsir_pkg::EXCESS_RETRY_ADDR))
        retry_ctl_q <= reg_wdata & lsir_pkg::EXCESS_RETRY_MASK;
    end
  end

  // Skip command is a one-cycle pulse
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n)
      drop_frame_cmd <= 1'b0;
    else if (clk_en)
      drop_frame_cmd <= reg_wr && reg_wdata[2]
                        && hit(bank_sel, reg_addr, lsir_pkg::BANK_BUFFER,
                               lsir_pkg::SKIP_FRAME_ADDR);
  end

  // Station address and hash table storage
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_tbl
      always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
          hash_q[gi] <= lsir_pkg::ZERO8;
        end else if (clk_en && reg_wr && bank_sel == lsir_pkg::BANK_HASH
                     && reg_addr == lsir_pkg::HASH_BYTE0_ADDR + 4'(gi)) begin
          hash_q[gi] <= reg_wdata;
        end
      end
      if (gi < 6) begin : g_sta
        always_ff @(posedge core_clk or negedge rst_n) begin
          if (!rst_n) begin
            station_q[gi] <= lsir_pkg::ZERO8;
          end else if (clk_en && reg_wr
                       && bank_sel == lsir_pkg::BANK_STATION
                       && reg_addr ==
                          lsir_pkg::STATION_ADDR_BYTE0_ADDR + 4'(gi)) begin
            station_q[gi] <= reg_wdata;
          end
        end
      end
    end
  endgenerate

  // Read data mux, registered
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= lsir_pkg::ZERO8;
    end else if (clk_en && reg_rd) begin
      reg_rdata <= lsir_pkg::ZERO8;
      if (!reg_addr[3]) begin
        case (reg_addr[2:0])
          3'h0: reg_rdata <= {tx_stat_q[7], carrier_image, tx_stat_q[5:4],
                              1'b0, tx_stat_q[2:1], 1'b0};
          3'h1: reg_rdata <= rx_stat_q;
          3'h2: reg_rdata <= tx_ien_q;
          3'h3: reg_rdata <= rx_ien_q;
          3'h4: reg_rdata <= {col_cnt_q, 1'b0, tx_mode_q[2:0]};
          3'h5: reg_rdata <= rx_mode_q;
          default: reg_rdata <= lsir_pkg::ZERO8;
        endcase
      end else begin
        case (bank_sel)
          lsir_pkg::BANK_STATION: begin
            if (reg_addr <= lsir_pkg::STATION_ADDR_BYTE5_ADDR)
              reg_rdata <= station_q[3'(reg_addr - 4'h8)];
          end
          lsir_pkg::BANK_HASH:
            reg_rdata <= hash_q[reg_addr[2:0]];
          lsir_pkg::BANK_BUFFER: begin
            case (reg_addr)
              lsir_pkg::EXCESS_RETRY_ADDR: reg_rdata <= retry_ctl_q;
              lsir_pkg::DMA_ENABLE_ADDR: reg_rdata <= dma_en_q;
              lsir_pkg::DMA_BURST_ADDR: reg_rdata <= burst_q;
              default: reg_rdata <= lsir_pkg::ZERO8;
            endcase
          end
          default: reg_rdata <= lsir_pkg::ZERO8;
        endcase
      end
    end
  end

  // Interrupt is OR of enabled status
  always_comb begin
    irq = |(tx_stat_q & tx_ien_q & lsir_pkg::TX_IRQ_MASK)
          | |(rx_stat_q & rx_ien_q);
  end

  assign dma_req_allow = !rx_stat_q[5];
  assign dma_enable = dma_en_q[1:0];
  assign dma_burst = burst_q[1:0];
  assign excess_retry_mode = retry_ctl_q[2:0];
  assign loopback_n = tx_mode_q[lsir_pkg::LOOPBACK_N_BIT];
endmodule

//--- sim/lsir_regs_chk.sv
`timescale 1ns/1ps
module lsir_regs_chk (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [1:0] bank_sel,
  input wire logic [3:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic carrier_sense,
  input wire logic dma_end_flag_n,
  input wire lsir_pkg::lsir_tx_ev_t tx_ev,
  input wire lsir_pkg::lsir_rx_ev_t rx_ev,
  input wire logic irq,
  input wire logic dma_req_allow,
  input wire logic retransmit,
  input wire logic frame_keep,
  input wire logic frame_discard,
  input wire lsir_pkg::lsir_rx_hdr_t rx_hdr,
  input wire logic loopback_n
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  logic good;
  logic [3:0] col_seen_q;
  assign good = rx_ev.frame_end && !rx_ev.crc_bad &&
    rx_ev.dribble_bits == 3'h0 && rx_ev.frame_len >= 11'd60;
  // Consecutive collisions of the current packet
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      col_seen_q <= 4'h0;
    end else if (tx_ev.tx_success || tx_ev.tx_start) begin
      col_seen_q <= 4'h0;
    end else if (tx_ev.collision) begin
      col_seen_q <= col_seen_q + 4'h1;
    end
  end
  property p_retransmit;
    retransmit == (tx_ev.collision && col_seen_q != 4'hf);
  endproperty
  a_retransmit: assert property (p_retransmit)
    else $error("retransmit without collision");
  property p_dma_block;
    $fell(dma_end_flag_n) |-> ##[2:6] !dma_req_allow;
  endproperty
  a_dma_block: assert property (p_dma_block)
    else $error("dma requests not blocked");
  property p_dma_clear;
    dma_end_flag_n [*5] ##0 (reg_wr && bank_sel == 2'h2 && reg_addr == 4'hc &&
      reg_wdata == 8'h00) |=> dma_req_allow;
  endproperty
  a_dma_clear: assert property (p_dma_clear)
    else $error("dma end flag not cleared");
  property p_irq_off;
    (reg_wr && reg_addr == 4'h2 && reg_wdata == 8'h00) ##2
      (reg_wr && reg_addr == 4'h3 && reg_wdata == 8'h00) |=> !irq;
  endproperty
  a_irq_off: assert property (p_irq_off)
    else $error("irq with all enables off");
  property p_carrier;
    $stable(carrier_sense) [*5] ##0 (reg_rd && reg_addr == 4'h0) |=>
      reg_rdata[6] == $past(carrier_sense);
  endproperty
  a_carrier: assert property (p_carrier)
    else $error("carrier image wrong");
  property p_keep;
    good |-> frame_keep && !frame_discard;
  endproperty
  a_keep: assert property (p_keep)
    else $error("good frame not kept");
  property p_hdr;
    good |=> rx_hdr.len_low == $past(rx_ev.frame_len[7:0]) &&
      rx_hdr.len_high == {5'h00, $past(rx_ev.frame_len[10:8])} &&
      rx_hdr.reserved == 8'h00 && rx_hdr.status[5];
  endproperty
  a_hdr: assert property (p_hdr)
    else $error("receive header wrong");
  property p_loopback;
    (reg_wr && reg_addr == 4'h4) |=> loopback_n == $past(reg_wdata[1]);
  endproperty
  a_loopback: assert property (p_loopback)
    else $error("loopback control wrong");
  c_good: cover property (good);
  c_eop: cover property ($fell(dma_end_flag_n));
  c_limit: cover property (tx_ev.collision && !retransmit);
endmodule

bind lsir_regs lsir_regs_chk lsir_regs_chk_i (.core_clk, .rst_n, .bank_sel,
  .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata, .carrier_sense,
  .dma_end_flag_n, .tx_ev, .rx_ev, .irq, .dma_req_allow, .retransmit,
  .frame_keep, .frame_discard, .rx_hdr, .loopback_n);

//--- sim/lsir_host.sv
`timescale 1ns/1ps
module lsir_host (
  input wire logic core_clk,
  output logic [1:0] bank_sel,
  output logic [3:0] reg_addr,
  output logic reg_wr,
  output logic reg_rd,
  output logic [7:0] reg_wdata,
  output logic dma_end_flag_n
);
  initial begin
    bank_sel = 2'h0;
    reg_addr = 4'h0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_wdata = 8'h00;
    dma_end_flag_n = 1'b1;
  end
  task automatic access(input logic w, input logic [1:0] b,
    input logic [3:0] a, input logic [7:0] d);
    @(negedge core_clk);
    bank_sel = b;
    reg_addr = a;
    reg_wdata = d;
    reg_wr = w;
    reg_rd = !w;
    @(negedge core_clk);
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_wdata = ~d;
    reg_addr = ~a;
    bank_sel = ~b;
  endtask
  // End of process held low for two cycles, then released
  task automatic eop;
    @(negedge core_clk);
    dma_end_flag_n = 1'b0;
    repeat (2) @(negedge core_clk);
    dma_end_flag_n = 1'b1;
  endtask
endmodule

//--- sim/lsir_regs_bench.sv
`timescale 1ns/1ps
module lsir_regs_bench;
  logic core_clk, rst_n, carrier_sense, buf_rd_strobe, buf_rd_ready;
  logic reg_wr, reg_rd, dma_end_flag_n, irq, dma_req_allow, retransmit, clk_en;
  logic [1:0] bank_sel, dma_enable;
  logic [3:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata;
  lsir_pkg::lsir_tx_ev_t tx_ev;
  lsir_pkg::lsir_rx_ev_t rx_ev;
  logic [7:0] exp_q[$];
  logic [31:0] seed = 32'h9693;
  int fails = 0;
  int checks_done = 0;
  lsir_regs lsir_regs_i (.core_clk, .rst_n, .clk_en, .bank_sel,
    .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata, .carrier_sense,
    .dma_end_flag_n, .buf_rd_strobe, .buf_rd_ready, .tx_ev, .rx_ev, .irq,
    .dma_req_allow, .retransmit, .frame_keep(), .frame_discard(),
    .rx_hdr(), .dma_enable, .dma_burst(), .excess_retry_mode(),
    .drop_frame_cmd(), .loopback_n());
  lsir_host lsir_host_i (.core_clk, .bank_sel, .reg_addr, .reg_wr, .reg_rd,
    .reg_wdata, .dma_end_flag_n);
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] r;
    r = s ^ (s << 13);
    r = r ^ (r >> 17);
    return r ^ (r << 5);
  endfunction
  task automatic check(input string what, input logic [7:0] seen,
    input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic summarize;
    $display("checks %0d fails %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic wr(input logic [1:0] b, input logic [3:0] a,
    input logic [7:0] d);
    lsir_host_i.access(1'b1, b, a, d);
  endtask
  task automatic rd(input logic [1:0] b, input logic [3:0] a,
    input logic [7:0] e);
    exp_q.push_back(e);
    lsir_host_i.access(1'b0, b, a, 8'h00);
  endtask
  task automatic txp(input lsir_pkg::lsir_tx_ev_t e);
    @(negedge core_clk);
    tx_ev = e;
    @(negedge core_clk);
    tx_ev = '0;
    tx_ev.tx_active = e.tx_active;
  endtask
  task automatic rxcase(input logic [10:0] len, input logic [15:0] ty,
    input logic [2:0] db, input logic crc, input logic full,
    input logic [7:0] e);
    @(negedge core_clk);
    rx_ev = '0;
    rx_ev.frame_end = !full;
    rx_ev.buffer_full = full;
    rx_ev.frame_stored = !full && !crc && db == 3'h0 && len >= 11'd60;
    rx_ev.frame_len = len;
    rx_ev.type_field = ty;
    rx_ev.dribble_bits = db;
    rx_ev.crc_bad = crc;
    @(negedge core_clk);
    rx_ev = '0;
    rd(2'h0, 4'h1, e);
    check("irq", irq, {7'h00, e == 8'h02});
    wr(2'h0, 4'h1, ~e & 8'hdf);
    rd(2'h0, 4'h1, e);
    wr(2'h0, 4'h1, e);
    rd(2'h0, 4'h1, 8'h00);
    check("irq", irq, 8'h00);
  endtask
  always @(posedge core_clk) begin
    if (reg_rd === 1'b1) begin
      @(negedge core_clk);
      if (exp_q.size() == 0) check("queue", 8'h01, 8'h00);
      else check("reg_rdata", reg_rdata, exp_q.pop_front());
    end
  end
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end
  initial begin
    repeat (20000) @(posedge core_clk);
    fails++;
    summarize();
  end
  initial begin
    rst_n = 1'b0;
    clk_en = 1'b1;
    carrier_sense = 1'b0;
    buf_rd_strobe = 1'b0;
    buf_rd_ready = 1'b0;
    tx_ev = '0;
    rx_ev = '0;
    repeat (3) @(negedge core_clk);
    rst_n = 1'b1;
    rd(2'h0, 4'h2, 8'h00);
    rd(2'h0, 4'h1, 8'h00);
    rd(2'h0, 4'h0, 8'h00);
    rd(2'h3, 4'h8, 8'h00);
    rd(2'h2, 4'hf, 8'h00);
    check("irq", irq, 8'h00);
    for (int i = 0; i < 4; i++) begin
      seed = xs(seed);
      wr(2'h0, 4'h8, seed[7:0]);
      rd(2'h0, 4'h8, seed[7:0]);
      wr(2'h1, 4'h8, seed[15:8]);
      rd(2'h1, 4'h8, seed[15:8]);
    end
    $display("reset and registers done");
    wr(2'h0, 4'h2, 8'hff);
    rd(2'h0, 4'h2, 8'h86);
    txp(6'b010000);
    rd(2'h0, 4'h0, 8'h80);
    check("irq", irq, 8'h01);
    wr(2'h0, 4'h0, 8'h00);
    rd(2'h0, 4'h0, 8'h80);
    wr(2'h0, 4'h0, 8'h80);
    rd(2'h0, 4'h0, 8'h00);
    check("irq", irq, 8'h00);
    for (int i = 0; i < 16; i++) begin
      @(negedge core_clk);
      tx_ev.collision = 1'b1;
      #1;
      check("retransmit", retransmit, {7'h00, i < 15});
      @(negedge core_clk);
      tx_ev.collision = 1'b0;
    end
    rd(2'h0, 4'h0, 8'h06);
    check("irq", irq, 8'h01);
    wr(2'h0, 4'h0, 8'h06);
    rd(2'h0, 4'h0, 8'h00);
    $display("transmit status done");
    carrier_sense = 1'b1;
    repeat (6) @(negedge core_clk);
    rd(2'h0, 4'h0, 8'h40);
    txp(6'b000011);
    carrier_sense = 1'b0;
    repeat (6) @(negedge core_clk);
    tx_ev.tx_active = 1'b0;
    wr(2'h0, 4'h0, 8'h30);
    rd(2'h0, 4'h0, 8'h30);
    wr(2'h0, 4'h0, 8'h80);
    txp(6'b100000);
    rd(2'h0, 4'h0, 8'h00);
    $display("transmit start done");
    wr(2'h0, 4'h3, 8'h02);
    rxcase(11'd100, 16'h0900, 3'h0, 1'b0, 1'b0, 8'h90);
    rxcase(11'd60, 16'h0901, 3'h0, 1'b0, 1'b0, 8'h80);
    rxcase(11'd59, 16'h0000, 3'h0, 1'b0, 1'b0, 8'h08);
    rxcase(11'd80, 16'h0000, 3'h1, 1'b0, 1'b0, 8'h04);
    rxcase(11'd80, 16'h0000, 3'h7, 1'b0, 1'b0, 8'h04);
    rxcase(11'd80, 16'h0000, 3'h0, 1'b1, 1'b0, 8'h02);
    rxcase(11'd0, 16'h0000, 3'h0, 1'b0, 1'b1, 8'h01);
    wr(2'h0, 4'h4, 8'h04);
    rxcase(11'd0, 16'h0000, 3'h0, 1'b0, 1'b1, 8'h00);
    wr(2'h0, 4'h4, 8'h06);
    for (int i = 0; i < 3; i++) begin
      seed = xs(seed);
      rxcase({1'b0, seed[9:0]} | 11'd64, seed[31:16], 3'h0, 1'b0, 1'b0,
        {3'h4, seed[31:16] == 16'h0900, 4'h0});
    end
    $display("receive status done");
    wr(2'h2, 4'hc, 8'h03);
    rd(2'h2, 4'hc, 8'h03);
    check("dma_enable", {6'h00, dma_enable}, 8'h03);
    lsir_host_i.eop();
    repeat (6) @(negedge core_clk);
    rd(2'h0, 4'h1, 8'h20);
    check("dma_req_allow", {7'h00, dma_req_allow}, 8'h00);
    wr(2'h0, 4'h1, 8'h00);
    rd(2'h0, 4'h1, 8'h20);
    wr(2'h2, 4'hc, 8'h00);
    rd(2'h0, 4'h1, 8'h00);
    check("dma_req_allow", {7'h00, dma_req_allow}, 8'h01);
    $display("dma end done");
    buf_rd_strobe = 1'b1;
    repeat (5) @(negedge core_clk);
    buf_rd_ready = 1'b1;
    @(negedge core_clk);
    buf_rd_strobe = 1'b0;
    buf_rd_ready = 1'b0;
    rd(2'h0, 4'h1, 8'h00);
    buf_rd_strobe = 1'b1;
    repeat (125) @(negedge core_clk);
    buf_rd_strobe = 1'b0;
    rd(2'h0, 4'h1, 8'h40);
    wr(2'h0, 4'h1, 8'h40);
    rd(2'h0, 4'h1, 8'h00);
    $display("read timeout done");
    clk_en = 1'b0;
    txp(6'b010000);
    clk_en = 1'b1;
    rd(2'h0, 4'h0, 8'h00);
    $display("clock enable done");
    wr(2'h0, 4'h2, 8'h80);
    txp(6'b010000);
    wr(2'h0, 4'h2, 8'h00);
    wr(2'h0, 4'h3, 8'h00);
    check("irq", irq, 8'h00);
    rd(2'h0, 4'h0, 8'h80);
    $display("interrupt mask done");
    repeat (4) @(negedge core_clk);
    summarize();
  end
endmodule
